/* File: logic/burst_sram.v */
// four-word double-rate burst memory with shared address bus
// k and k_n are link clocks sampled by clk_in; bench period 64 ns
`timescale 1ns/1ps
`include "burst_sram_defines.vh"
module burst_sram (
    input wire clk_in,
    input wire rst_in,
    input wire k_in,
    input wire k_n_in,
    input wire [`ADDR_W-1:0] addr_in,
    input wire read_sel_n_in,
    input wire write_sel_n_in,
    input wire [`WORD_W-1:0] wdata_in,
    input wire [1:0] byte_write_select_n_in,
    input wire pll_off_select_in,
    input wire rd_ready_in,
    output reg [`WORD_W-1:0] rdata_out,
    output reg read_valid_flag_out,
    output reg echo_clock_out,
    output reg echo_clock_n_out,
    output reg rd_valid_out
);
    // two-flop synchronisers for every pin but rst_in and rd_ready_in
    reg [1:0] k_s1_q, k_s2_q, k_s3_q;
    reg [`ADDR_W-1:0] a_s1_q, a_s2_q;
    reg [`WORD_W-1:0] d_s1_q, d_s2_q;
    reg [1:0] b_s1_q, b_s2_q;
    reg [2:0] c_s1_q, c_s2_q;
    // link clocks, third flop only for edge finding
    always @(posedge clk_in) begin
        k_s1_q <= {k_n_in, k_in};
        k_s2_q <= k_s1_q;
        k_s3_q <= k_s2_q;
    end

    // shared address, same depth as the link clocks
    always @(posedge clk_in) begin
        a_s1_q <= addr_in;
        a_s2_q <= a_s1_q;
    end

    // write word and byte selects
    always @(posedge clk_in) begin
        d_s1_q <= wdata_in;
        d_s2_q <= d_s1_q;
        b_s1_q <= byte_write_select_n_in;
        b_s2_q <= b_s1_q;
    end

    // port selects and latency select
    always @(posedge clk_in) begin
        c_s1_q <= {pll_off_select_in, write_sel_n_in, read_sel_n_in};
        c_s2_q <= c_s1_q;
    end
    wire k_rise = k_s2_q[0] & ~k_s3_q[0];
    wire kn_rise = k_s2_q[1] & ~k_s3_q[1];
    wire any_rise = k_rise | kn_rise;

    function [`WORD_W-1:0] merge;
        input [`WORD_W-1:0] old_w;
        input [`WORD_W-1:0] new_w;
        input [1:0] bw_n;
        begin
            merge = old_w;
            if (!bw_n[0])
                merge[8:0] = new_w[8:0];
            if (!bw_n[1])
                merge[17:9] = new_w[17:9];
        end
    endfunction

    reg [`WORD_W-1:0] mem_q [0:`DEPTH*`BURST_LEN-1];
    reg phase_q; // 0: next k rise is read address slot
    reg wr_act_q;
    reg [`ADDR_W-1:0] wr_next_q;
    reg [`ADDR_W-1:0] wr_addr_q;
    reg [1:0] wr_idx_q;
    reg wr_pend_q;
    reg [`ADDR_W-1:0] rd_addr_q;
    reg [2:0] rd_wait_q;
    reg rd_act_q;
    reg [1:0] rd_idx_q;
    // two-entry output buffer
    reg [`WORD_W-1:0] buf_q [0:1];
    reg [1:0] cnt_q;
    reg wp_q, rp_q;
    wire buf_full = cnt_q == 2'h2;
    // burst begins on the k rise after the write slot
    wire wr_start = wr_pend_q && k_rise;
    wire [`ADDR_W+1:0] wr_ptr = wr_start ? {wr_next_q, 2'h0} : {wr_addr_q, wr_idx_q};
    wire [`ADDR_W+1:0] rd_ptr = {rd_addr_q, rd_idx_q};
    wire rd_push = rd_act_q && rd_wait_q == 3'h0 && any_rise;
    wire rd_pop = rd_valid_out && rd_ready_in;
    // a write word lands on every link edge of a burst
    wire wr_word = any_rise && (wr_act_q || wr_start);
    wire wr_hit = wr_word && wr_ptr == rd_ptr;
    // bypass newest write word to the read path
    wire [`WORD_W-1:0] rd_word = wr_hit ? merge(mem_q[rd_ptr], d_s2_q, b_s2_q) : mem_q[rd_ptr];
    // slots alternate: read on one k rise, write on the next
    wire accept_rd = k_rise && !phase_q && !c_s2_q[0] && !buf_full;
    wire accept_wr = k_rise && phase_q && !c_s2_q[1];
    // a word enters the buffer only while a slot is free
    wire rd_store = rd_push && !buf_full;
    wire [1:0] cnt_d = cnt_q + {1'b0, rd_store} - {1'b0, rd_pop};
    // empty buffer forwards the arriving word straight to the head
    wire head_is_new = cnt_q == 2'h0 || (cnt_q == 2'h1 && rd_pop);
    wire [`WORD_W-1:0] head_d = head_is_new ? rd_word : (rd_pop ? buf_q[~rp_q] : buf_q[rp_q]);

    integer i;

    // echo clocks follow the synchronised link clocks
    always @(posedge clk_in) begin
        if (rst_in) begin
            phase_q <= 1'b0;
            echo_clock_out <= 1'b0;
            echo_clock_n_out <= 1'b1;
        end else begin
            echo_clock_out <= k_s2_q[0];
            echo_clock_n_out <= k_s2_q[1];
            if (k_rise)
                phase_q <= ~phase_q;
        end
    end

    // write side: address parked until its burst starts on the next k rise
    always @(posedge clk_in) begin
        if (rst_in) begin
            wr_pend_q <= 1'b0;
            wr_act_q <= 1'b0;
            wr_next_q <= {`ADDR_W{1'b0}};
            wr_addr_q <= {`ADDR_W{1'b0}};
            wr_idx_q <= 2'h0;
        end else begin
            if (accept_wr) begin
                wr_next_q <= a_s2_q;
                wr_pend_q <= 1'b1;
            end else if (wr_start) begin
                wr_pend_q <= 1'b0;
            end
            if (wr_start) begin
                // word 0 lands on this edge
                wr_addr_q <= wr_next_q;
                wr_idx_q <= 2'h1;
                wr_act_q <= 1'b1;
            end else if (wr_act_q && any_rise) begin
                wr_idx_q <= wr_idx_q + 2'h1;
                if (wr_idx_q == 2'h3)
                    wr_act_q <= 1'b0;
            end
        end
    end

    // self-timed internal write, one word per link edge
    always @(posedge clk_in) begin
        if (!rst_in && wr_word)
            mem_q[wr_ptr] <= merge(mem_q[wr_ptr], d_s2_q, b_s2_q);
    end

    // read side, independent of the write side
    always @(posedge clk_in) begin
        if (rst_in) begin
            rd_addr_q <= {`ADDR_W{1'b0}};
            rd_wait_q <= 3'h0;
            rd_act_q <= 1'b0;
            rd_idx_q <= 2'h0;
            read_valid_flag_out <= 1'b0;
        end else begin
            if (accept_rd) begin
                rd_addr_q <= a_s2_q;
                rd_idx_q <= 2'h0;
                rd_act_q <= 1'b1;
                rd_wait_q <= c_s2_q[2] ? `LAT_LONG_HALVES - 3'h1 : `LAT_SHORT_HALVES - 3'h1;
            end else if (rd_act_q && any_rise) begin
                if (rd_wait_q != 3'h0)
                    rd_wait_q <= rd_wait_q - 3'h1;
                else if (!buf_full) begin
                    // a full buffer holds the burst back, no word is dropped
                    rd_idx_q <= rd_idx_q + 2'h1;
                    if (rd_idx_q == 2'h3)
                        rd_act_q <= 1'b0;
                end
            end
            // flag tracks a read burst past its latency, not words on the output
            read_valid_flag_out <= rd_act_q && rd_wait_q == 3'h0;
        end
    end

    // buffer pointers and fill count move together
    always @(posedge clk_in) begin
        if (rst_in) begin
            cnt_q <= 2'h0;
            wp_q <= 1'b0;
            rp_q <= 1'b0;
        end else begin
            if (rd_store)
                wp_q <= ~wp_q;
            if (rd_pop)
                rp_q <= ~rp_q;
            cnt_q <= cnt_d;
        end
    end

    // buffer storage needs no reset, the count guards it
    always @(posedge clk_in) begin
        if (rd_store)
            buf_q[wp_q] <= rd_word;
    end

    always @(posedge clk_in) begin
        if (rst_in) begin
            rdata_out <= {`WORD_W{1'b0}};
            rd_valid_out <= 1'b0;
        end else begin
            rd_valid_out <= cnt_d != 2'h0;
            rdata_out <= head_d;
        end
    end

    // array starts cleared in simulation
    initial begin
        for (i = 0; i < `DEPTH*`BURST_LEN; i = i + 1)
            mem_q[i] = {`WORD_W{1'b0}};
    end
endmodule // burst_sram

/* File: logic/burst_sram_defines.vh */
// constants for the four-word double-rate burst memory front end
// assumes inclusion by the single design module
`ifndef BURST_SRAM_DEFINES_VH
`define BURST_SRAM_DEFINES_VH
`define WORD_W 18
`define ADDR_W 4
`define DEPTH 16
`define BURST_LEN 4
`define LAT_LONG_HALVES 3'h5
`define LAT_SHORT_HALVES 3'h2
`define EDGE_K 2'h1
`define EDGE_KN 2'h2
`endif

/* File: tb/burst_sram_properties.sv */
// port checks for burst_sram
// bound into every burst_sram
`timescale 1ns/1ps
module burst_sram_properties (
    input wire clk_in,
    input wire rst_in,
    input wire k_in,
    input wire k_n_in,
    input wire rd_ready_in,
    input wire [17:0] rdata_out,
    input wire rd_valid_out,
    input wire read_valid_flag_out,
    input wire echo_clock_out,
    input wire echo_clock_n_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    property p_rv; disable iff (1'b0) rst_in |=> !rd_valid_out && !read_valid_flag_out; endproperty
    a_rv: assert property (p_rv) else $error("valid after reset");
    property p_re; disable iff (1'b0) rst_in |=> !echo_clock_out && echo_clock_n_out; endproperty
    a_re: assert property (p_re) else $error("echo after reset");
    property p_hv; rd_valid_out && !rd_ready_in |=> rd_valid_out; endproperty
    a_hv: assert property (p_hv) else $error("valid dropped");
    property p_hd; rd_valid_out && !rd_ready_in |=> $stable(rdata_out); endproperty
    a_hd: assert property (p_hd) else $error("data moved");
    property p_ek; $rose(k_in) |-> ##[1:5] echo_clock_out; endproperty
    a_ek: assert property (p_ek) else $error("echo late");
    property p_en; $rose(k_n_in) |-> ##[1:5] echo_clock_n_out; endproperty
    a_en: assert property (p_en) else $error("echo n late");
    property p_eq; $stable(k_in) [*6] |-> $stable(echo_clock_out); endproperty
    a_eq: assert property (p_eq) else $error("echo moved");
    property p_vf; $rose(rd_valid_out) |-> $past(read_valid_flag_out) || $past(read_valid_flag_out, 2); endproperty
    a_vf: assert property (p_vf) else $error("valid without flag");
endmodule // burst_sram_properties
bind burst_sram burst_sram_properties props (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .k_in(k_in),
    .k_n_in(k_n_in),
    .rd_ready_in(rd_ready_in),
    .rdata_out(rdata_out),
    .rd_valid_out(rd_valid_out),
    .read_valid_flag_out(read_valid_flag_out),
    .echo_clock_out(echo_clock_out),
    .echo_clock_n_out(echo_clock_n_out)
);

/* File: tb/link_clock_model.sv */
// free-running complementary link clock pair, 64 ns period
// drives k_in and k_n_in of the memory
`timescale 1ns/1ps
module link_clock_model (
    output reg k_out = 1'b0,
    output reg k_n_out = 1'b1
);
    initial begin
        #1.3;
        forever begin
            #32 k_out = ~k_out;
            k_n_out = ~k_out;
        end
    end
endmodule // link_clock_model

/* File: tb/tb.sv */
// bench: write bursts, read back at both latencies
// link clocks from link_clock_model
`timescale 1ns/1ps
module tb;
    reg clk_in = 1'b0, rst_in = 1'b1, read_sel_n_in = 1'b1, write_sel_n_in = 1'b1;
    reg pll_off_select_in = 1'b1, rd_ready_in = 1'b1, par = 1'b0;
    reg [3:0] addr_in = 4'h0;
    reg [1:0] byte_write_select_n_in = 2'h0;
    reg [17:0] wdata_in = 18'h0, m [0:63];
    wire k_in, k_n_in, rd_valid_out, read_valid_flag_out, echo_clock_out, echo_clock_n_out;
    wire [17:0] rdata_out;
    integer num_errors = 0, n_checks = 0, cycles = 0, i;
    link_clock_model partner (.k_out(k_in), .k_n_out(k_n_in));
    burst_sram dut (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .k_in(k_in),
        .k_n_in(k_n_in),
        .addr_in(addr_in),
        .read_sel_n_in(read_sel_n_in),
        .write_sel_n_in(write_sel_n_in),
        .wdata_in(wdata_in),
        .byte_write_select_n_in(byte_write_select_n_in),
        .pll_off_select_in(pll_off_select_in),
        .rd_ready_in(rd_ready_in),
        .rdata_out(rdata_out),
        .read_valid_flag_out(read_valid_flag_out),
        .echo_clock_out(echo_clock_out),
        .echo_clock_n_out(echo_clock_n_out),
        .rd_valid_out(rd_valid_out)
    );
    initial forever #2.5 clk_in = ~clk_in;
    // parity of k rises: 0 after a write slot
    always @(posedge k_in) par <= rst_in ? 1'b0 : ~par;
    always @(posedge clk_in) begin
        cycles = cycles + 1;
        if (cycles > 9000) begin
            num_errors = num_errors + 1;
            end_sim;
        end
    end
    // inputs change mid-way between link edges
    task step(input integer n);
        repeat (n) begin
            @(posedge k_in or posedge k_n_in);
            repeat (4) @(posedge clk_in);
        end
    endtask
    task check(input [17:0] e, input [17:0] s);
        begin
            n_checks = n_checks + 1;
            if (s !== e) begin
                num_errors = num_errors + 1;
                $display("mismatch rdata_out expected %h seen %h", e, s);
            end
        end
    endtask
    task check_bit(input e, input s);
        begin
            n_checks = n_checks + 1;
            if (s !== e) begin
                num_errors = num_errors + 1;
                $display("mismatch rd_valid_out expected %b seen %b", e, s);
            end
        end
    endtask
    task reset_dut(input pll);
        begin
            rst_in <= 1'b1;
            pll_off_select_in <= pll;
            repeat (6) @(posedge clk_in);
            step(1);
            rst_in <= 1'b0;
        end
    endtask
    task xfer(input [3:0] a, input [17:0] d, input [1:0] bw);
        begin
            do @(posedge k_n_in); while (par !== 1'b0);
            repeat (4) @(posedge clk_in);
            addr_in <= a;
            byte_write_select_n_in <= bw;
            step(2);
            write_sel_n_in <= 1'b0;
            step(2);
            write_sel_n_in <= 1'b1;
            for (i = 0; i < 4; i = i + 1) begin
                wdata_in <= d;
                m[a * 4 + i] = (d & {{9{~bw[1]}}, {9{~bw[0]}}}) | (m[a * 4 + i] & {{9{bw[1]}}, {9{bw[0]}}});
                d = d + 18'h1;
                step(1);
            end
            read_sel_n_in <= 1'b0;
            rd_ready_in <= 1'b0;
            step(2);
            read_sel_n_in <= 1'b1;
            // stall the reader past the whole burst
            repeat (100) @(posedge clk_in);
            rd_ready_in <= 1'b1;
            for (i = 0; i < 4; i = i + 1) begin
                @(negedge clk_in);
                while (rd_valid_out !== 1'b1) @(negedge clk_in);
                check(m[a * 4 + i], rdata_out);
                @(posedge clk_in);
            end
            repeat (60) @(posedge clk_in);
            check_bit(1'b0, rd_valid_out);
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d errors %0d", n_checks, num_errors);
            if (num_errors == 0 && n_checks > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    initial begin
        reset_dut(1'b1);
        xfer(4'h3, 18'h3A5C0, 2'h0);
        xfer(4'h3, 18'h155A0, 2'h1);
        xfer(4'hF, 18'h3FFFC, 2'h0);
        reset_dut(1'b0);
        xfer(4'h0, 18'h0C3C3, 2'h0);
        end_sim;
    end
endmodule // tb
